// ### src/ucr_chan_regs.sv
// Register map of one serial channel behind the byte-wide register port
`timescale 1ns/1ps
//
// Contract
// - Four address lines select sixteen locations; lower eight classic, offset eight feature control, the other upper seven read zero.
// - Divisor access clear: read at zero returns the newest received byte.
// - Divisor access clear: write at zero loads the transmit holding byte.
// - Divisor access set: offsets zero, one, two reach divisor low, high, fraction.
// - Fraction register: fraction, fast infrared, flow char parity, multidrop, direction invert.
// - Shaded bits write and act only with enhanced enable; otherwise read zero.
// - Interrupt enables: data, transmit empty, line, modem; bit 4 zero; three enhanced.
// - Interrupt status: source code, special char, flow change, fifos enabled.
// - Fifo control: enable, receive reset, transmit reset, dma, transmit and receive triggers.
// - Line control: word length, stop, parity enable, even, force, break, divisor access.
// - Modem control: dtr, rts, flow select, send now, loopback, resume, infrared, prescaler.
// - Line status: ready, overrun, parity, framing, break, holding empty, shift empty, fifo error.
// - Modem status: change flags in bits 3:0, current levels in bits 7:4.
// - Write at modem status offset: four disables and a four-bit turnaround delay.
// - Scratch byte stores any write and returns it unchanged.
// - Feature control: hysteresis, infrared invert, auto direction, trigger table.
module ucr_chan_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic rd_valid,
	input wire logic enh_enable,
	input wire logic rx_push,
	input wire logic [7:0] rx_byte,
	input wire logic ln_parity_err,
	input wire logic ln_framing_err,
	input wire logic ln_break,
	input wire logic ln_thr_empty,
	input wire logic ln_tsr_empty,
	input wire logic ln_fifo_err,
	input wire logic [3:0] isr_source,
	input wire logic isr_special,
	input wire logic isr_flow_delta,
	input wire logic cts_lvl,
	input wire logic dsr_lvl,
	input wire logic ri_lvl,
	input wire logic cd_lvl,
	output logic tx_load,
	output logic [7:0] tx_byte,
	output logic [15:0] divisor,
	output logic [3:0] baud_fraction,
	output logic fast_ir,
	output logic flow_char_parity,
	output logic multidrop,
	output logic rs485_invert,
	output logic [7:0] int_enable,
	output logic fifo_enable,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic dma_mode,
	output logic [1:0] tx_trigger,
	output logic [1:0] rx_trigger,
	output logic [1:0] word_length,
	output logic stop_bits,
	output logic parity_enable,
	output logic even_parity,
	output logic force_parity,
	output logic send_break,
	output logic divisor_access,
	output logic dtr_ctl,
	output logic rts_ctl,
	output logic flow_select,
	output logic tx_immediate,
	output logic loopback,
	output logic resume_on_any_char,
	output logic ir_enable,
	output logic baud_prescale,
	output logic rx_mode_disable,
	output logic tx_mode_disable,
	output logic rx_disable,
	output logic tx_disable,
	output logic [3:0] turnaround_delay,
	output logic [3:0] flow_hysteresis,
	output logic ir_rx_invert,
	output logic auto_rs485,
	output logic [1:0] trigger_table
);
	typedef struct packed {
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic [7:0] divisor_fraction_options;
		logic [7:0] interrupt_enable;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] ddd;
		logic [7:0] scratch_pad;
		logic [7:0] feature_control;
		logic [7:0] rdata;
		logic [7:0] tx_byte;
		logic tx_load;
		logic rd_valid;
		logic rx_rst;
		logic tx_rst;
	} ucr_top_s;

	localparam ucr_top_s TOP_RST = '{
		dll: ucr_pkg::RST_DLL,
		divisor_high_byte: ucr_pkg::RST_DLM,
		divisor_fraction_options: ucr_pkg::RST_DLD,
		interrupt_enable: ucr_pkg::RST_IER,
		fifo_control: ucr_pkg::RST_FCR,
		line_control: ucr_pkg::RST_LCR,
		modem_control: ucr_pkg::RST_MCR,
		ddd: ucr_pkg::RST_DDD,
		scratch_pad: ucr_pkg::RST_SPR,
		feature_control: ucr_pkg::RST_FEATURE_CONTROL,
		rdata: 8'h00,
		tx_byte: 8'h00,
		tx_load: 1'b0,
		rd_valid: 1'b0,
		rx_rst: 1'b0,
		tx_rst: 1'b0
	};

	ucr_top_s s_q, s_d;
	ucr_side_if sif ();

	// Hide enhanced bits while enhanced functions are off
	function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m, input logic en);
		gate = en ? v : (v & ~m);
	endfunction

	// Enhanced bits keep their old value on a write while enhanced functions are off
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
		input logic [7:0] m, input logic en);
		merge = en ? nv : ((nv & ~m) | (old & m));
	endfunction

	logic dla;
	logic [7:0] ier_eff;
	logic [7:0] fcr_eff;
	logic [7:0] mcr_eff;
	logic [7:0] isr_val;
	logic [7:0] lsr_val;
	logic [7:0] msr_val;
	logic [7:0] rd_mux;

	assign dla = s_q.line_control[ucr_pkg::LCR_DIV];

	// Effective views: enhanced bits act only while enabled
	assign ier_eff = gate(s_q.interrupt_enable, ucr_pkg::IER_ENH, enh_enable);
	assign fcr_eff = gate(s_q.fifo_control, ucr_pkg::FCR_ENH, enh_enable);
	assign mcr_eff = gate(s_q.modem_control, ucr_pkg::MCR_ENH, enh_enable);

	// Status bytes assembled from the channel's own state
	assign isr_val = gate({{2{s_q.fifo_control[ucr_pkg::FCR_EN]}}, isr_flow_delta, isr_special, isr_source},
		ucr_pkg::ISR_ENH, enh_enable);
	assign lsr_val = {ln_fifo_err, ln_tsr_empty, ln_thr_empty, ln_break, ln_framing_err,
		ln_parity_err, sif.overrun, sif.rhr_ready};
	assign msr_val = {sif.modem_lvl, sif.modem_delta};

	// Side effects of reads: pop the received byte, clear overrun and change flags
	assign sif.modem_lvl = {cd_lvl, ri_lvl, dsr_lvl, cts_lvl};
	assign sif.rx_push = rx_push;
	assign sif.rx_byte = rx_byte;
	assign sif.rhr_pop = reg_rd && (reg_addr == ucr_pkg::OFS_HOLD) && !dla;
	assign sif.lsr_read = reg_rd && (reg_addr == ucr_pkg::OFS_LSR);
	assign sif.msr_read = reg_rd && (reg_addr == ucr_pkg::OFS_MSR);

	ucr_modem_delta u_delta (
		.clk(clk),
		.srst(srst),
		.sif(sif.delta)
	);

	ucr_rx_hold u_hold (
		.clk(clk),
		.srst(srst),
		.sif(sif.hold)
	);

	// Read multiplexer over the sixteen locations; unbuilt upper ones read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			ucr_pkg::OFS_HOLD:
				rd_mux = dla ? s_q.dll : sif.rhr_byte;
			ucr_pkg::OFS_IER:
				rd_mux = dla ? s_q.divisor_high_byte : ier_eff;
			ucr_pkg::OFS_ISR:
				rd_mux = dla ? s_q.divisor_fraction_options : isr_val;
			ucr_pkg::OFS_LCR:
				rd_mux = s_q.line_control;
			ucr_pkg::OFS_MCR:
				rd_mux = mcr_eff;
			ucr_pkg::OFS_LSR:
				rd_mux = lsr_val;
			ucr_pkg::OFS_MSR:
				rd_mux = msr_val;
			ucr_pkg::OFS_SPR:
				rd_mux = s_q.scratch_pad;
			ucr_pkg::OFS_FEATURE_CONTROL:
				rd_mux = s_q.feature_control;
			default:
				rd_mux = 8'h00;
		endcase
	end

	// Next state: pulses drop each cycle, writes land by offset and divisor access
	always_comb begin
		s_d = s_q;
		s_d.tx_load = 1'b0;
		s_d.rx_rst = 1'b0;
		s_d.tx_rst = 1'b0;
		s_d.rd_valid = reg_rd;
		if (reg_rd)
			s_d.rdata = rd_mux;
		if (reg_wr) begin
			unique case (reg_addr)
				ucr_pkg::OFS_HOLD: begin
					if (dla) begin
						s_d.dll = reg_wdata;
					end else begin
						s_d.tx_byte = reg_wdata;
						s_d.tx_load = 1'b1;
					end
				end
				ucr_pkg::OFS_IER: begin
					if (dla)
						s_d.divisor_high_byte = reg_wdata;
					else
						s_d.interrupt_enable = merge(s_q.interrupt_enable, reg_wdata & ucr_pkg::IER_KEEP,
							ucr_pkg::IER_ENH, enh_enable);
				end
				ucr_pkg::OFS_ISR: begin
					if (dla) begin
						s_d.divisor_fraction_options = reg_wdata;
					end else begin
						s_d.fifo_control = merge(s_q.fifo_control, reg_wdata & ucr_pkg::FCR_KEEP,
							ucr_pkg::FCR_ENH, enh_enable);
						s_d.rx_rst = reg_wdata[ucr_pkg::FCR_RX_RST];
						s_d.tx_rst = reg_wdata[ucr_pkg::FCR_TX_RST];
					end
				end
				ucr_pkg::OFS_LCR:
					s_d.line_control = reg_wdata;
				ucr_pkg::OFS_MCR:
					s_d.modem_control = merge(s_q.modem_control, reg_wdata, ucr_pkg::MCR_ENH, enh_enable);
				ucr_pkg::OFS_MSR: begin
					// Write-only twin of modem status exists only in enhanced mode
					if (enh_enable)
						s_d.ddd = reg_wdata;
				end
				ucr_pkg::OFS_SPR:
					s_d.scratch_pad = reg_wdata;
				ucr_pkg::OFS_FEATURE_CONTROL:
					s_d.feature_control = reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Single state register
	always_ff @(posedge clk) begin
		if (srst)
			s_q <= TOP_RST;
		else
			s_q <= s_d;
	end

	// Register port answer, one cycle after the read strobe
	assign reg_rdata = s_q.rdata;
	assign rd_valid = s_q.rd_valid;
	assign tx_load = s_q.tx_load;
	assign tx_byte = s_q.tx_byte;

	// Divisor and fraction fields
	assign divisor = {s_q.divisor_high_byte, s_q.dll};
	assign baud_fraction = s_q.divisor_fraction_options[ucr_pkg::DLD_FRAC_LO +: 4];
	assign fast_ir = s_q.divisor_fraction_options[ucr_pkg::DLD_FAST_IR];
	assign flow_char_parity = s_q.divisor_fraction_options[ucr_pkg::DLD_CHAR_PAR];
	assign multidrop = s_q.divisor_fraction_options[ucr_pkg::DLD_MULTIDROP];
	assign rs485_invert = s_q.divisor_fraction_options[ucr_pkg::DLD_INV485];

	// Interrupt enables as they act
	assign int_enable = ier_eff;

	// Fifo control fields; triggers of the transmit side are enhanced
	assign fifo_enable = fcr_eff[ucr_pkg::FCR_EN];
	assign rx_fifo_reset = s_q.rx_rst;
	assign tx_fifo_reset = s_q.tx_rst;
	assign dma_mode = fcr_eff[ucr_pkg::FCR_DMA];
	assign tx_trigger = fcr_eff[ucr_pkg::FCR_TX_TRG +: 2];
	assign rx_trigger = fcr_eff[ucr_pkg::FCR_RX_TRG +: 2];

	// Line control fields
	assign word_length = s_q.line_control[ucr_pkg::LCR_WLEN +: 2];
	assign stop_bits = s_q.line_control[ucr_pkg::LCR_STOP];
	assign parity_enable = s_q.line_control[ucr_pkg::LCR_PAR_EN];
	assign even_parity = s_q.line_control[ucr_pkg::LCR_EVEN];
	assign force_parity = s_q.line_control[ucr_pkg::LCR_FORCE];
	assign send_break = s_q.line_control[ucr_pkg::LCR_BREAK];
	assign divisor_access = dla;

	// Modem control fields; upper three act only in enhanced mode
	assign dtr_ctl = mcr_eff[ucr_pkg::MCR_DTR];
	assign rts_ctl = mcr_eff[ucr_pkg::MCR_RTS];
	assign flow_select = mcr_eff[ucr_pkg::MCR_FLOW_SEL];
	assign tx_immediate = mcr_eff[ucr_pkg::MCR_TX_NOW];
	assign loopback = mcr_eff[ucr_pkg::MCR_LOOP];
	assign resume_on_any_char = mcr_eff[ucr_pkg::MCR_ANY];
	assign ir_enable = mcr_eff[ucr_pkg::MCR_IR];
	assign baud_prescale = mcr_eff[ucr_pkg::MCR_PRESC];

	// Direction delay and disables; held value stays gated when enhanced drops
	assign rx_mode_disable = enh_enable && s_q.ddd[ucr_pkg::DDD_RX_MODE];
	assign tx_mode_disable = enh_enable && s_q.ddd[ucr_pkg::DDD_TX_MODE];
	assign rx_disable = enh_enable && s_q.ddd[ucr_pkg::DDD_RX];
	assign tx_disable = enh_enable && s_q.ddd[ucr_pkg::DDD_TX];
	assign turnaround_delay = enh_enable ? s_q.ddd[ucr_pkg::DDD_DLY +: 4] : 4'h0;

	// Feature control fields
	assign flow_hysteresis = s_q.feature_control[ucr_pkg::FEATURE_CONTROL_HYST +: 4];
	assign ir_rx_invert = s_q.feature_control[ucr_pkg::FEATURE_CONTROL_IR_INV];
	assign auto_rs485 = s_q.feature_control[ucr_pkg::FEATURE_CONTROL_AUTO485];
	assign trigger_table = s_q.feature_control[ucr_pkg::FEATURE_CONTROL_TRG +: 2];
endmodule // ucr_chan_regs

// ### src/ucr_modem_delta.sv
// Sticky change flags of the four modem inputs
`timescale 1ns/1ps
module ucr_modem_delta (
	input wire logic clk,
	input wire logic srst,
	ucr_side_if.delta sif
);
	typedef struct packed {
		logic primed;
		logic [3:0] prev;
		logic [3:0] delta;
	} ucr_dlt_s;
	ucr_dlt_s s_q, s_d;

	// First cycle after reset only samples, so no false change is flagged
	always_comb begin
		s_d = s_q;
		s_d.primed = 1'b1;
		s_d.prev = sif.modem_lvl;
		for (int i = 0; i < 4; i++) begin
			if (sif.msr_read)
				s_d.delta[i] = 1'b0;
			if (s_q.primed && (s_q.prev[i] != sif.modem_lvl[i]))
				s_d.delta[i] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sif.modem_delta = s_q.delta;
endmodule // ucr_modem_delta

// ### src/ucr_pkg.sv
// Offsets, field positions, masks and reset values of the channel register map
package ucr_pkg;
	// Register offsets on the four address lines
	localparam logic [3:0] OFS_HOLD = 4'h0, OFS_IER = 4'h1, OFS_ISR = 4'h2, OFS_LCR = 4'h3;
	localparam logic [3:0] OFS_MCR = 4'h4, OFS_LSR = 4'h5, OFS_MSR = 4'h6, OFS_SPR = 4'h7;
	localparam logic [3:0] OFS_FEATURE_CONTROL = 4'h8;
	// Divisor fraction and options
	localparam int DLD_FRAC_LO = 0, DLD_FAST_IR = 4, DLD_CHAR_PAR = 5, DLD_MULTIDROP = 6, DLD_INV485 = 7;
	// Interrupt status
	localparam int ISR_SRC_LO = 0, ISR_FIFO_LO = 6;
	// Fifo control
	localparam int FCR_EN = 0, FCR_RX_RST = 1, FCR_TX_RST = 2, FCR_DMA = 3, FCR_TX_TRG = 4, FCR_RX_TRG = 6;
	// Line control
	localparam int LCR_WLEN = 0, LCR_STOP = 2, LCR_PAR_EN = 3, LCR_EVEN = 4, LCR_FORCE = 5;
	localparam int LCR_BREAK = 6, LCR_DIV = 7;
	// Modem control
	localparam int MCR_DTR = 0, MCR_RTS = 1, MCR_FLOW_SEL = 2, MCR_TX_NOW = 3, MCR_LOOP = 4;
	localparam int MCR_ANY = 5, MCR_IR = 6, MCR_PRESC = 7;
	// Direction delay and disable, written at the modem status offset
	localparam int DDD_RX_MODE = 0, DDD_TX_MODE = 1, DDD_RX = 2, DDD_TX = 3, DDD_DLY = 4;
	// Feature control
	localparam int FEATURE_CONTROL_HYST = 0, FEATURE_CONTROL_IR_INV = 4, FEATURE_CONTROL_AUTO485 = 5, FEATURE_CONTROL_TRG = 6;
	// Bits that exist only with enhanced functions on
	localparam logic [7:0] IER_ENH = 8'he0, ISR_ENH = 8'h30, FCR_ENH = 8'h30, MCR_ENH = 8'he0;
	// Bits that are held at all; interrupt enable bit 4 reads zero, fifo resets self clear
	localparam logic [7:0] IER_KEEP = 8'hef, FCR_KEEP = 8'hf9;
	// Reset values
	localparam logic [7:0] RST_DLL = 8'h00, RST_DLM = 8'h00, RST_DLD = 8'h00, RST_IER = 8'h00;
	localparam logic [7:0] RST_FCR = 8'h00, RST_LCR = 8'h00, RST_MCR = 8'h00, RST_DDD = 8'h00;
	localparam logic [7:0] RST_SPR = 8'h00, RST_FEATURE_CONTROL = 8'h00;
endpackage

// ### src/ucr_rx_hold.sv
// Receive holding byte with data ready and overrun flags
`timescale 1ns/1ps
module ucr_rx_hold (
	input wire logic clk,
	input wire logic srst,
	ucr_side_if.hold sif
);
	typedef struct packed {
		logic [7:0] data;
		logic ready;
		logic overrun;
	} ucr_hold_s;
	ucr_hold_s s_q, s_d;

	// A push in the cycle of the pop or clear wins
	always_comb begin
		s_d = s_q;
		if (sif.rhr_pop)
			s_d.ready = 1'b0;
		if (sif.lsr_read)
			s_d.overrun = 1'b0;
		if (sif.rx_push) begin
			s_d.data = sif.rx_byte;
			s_d.ready = 1'b1;
			if (s_q.ready && !sif.rhr_pop)
				s_d.overrun = 1'b1; // Unread byte lost
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sif.rhr_byte = s_q.data;
	assign sif.rhr_ready = s_q.ready;
	assign sif.overrun = s_q.overrun;
endmodule // ucr_rx_hold

// ### src/ucr_side_if.sv
// Bundle between the register map and its modem change and receive holding helpers
`timescale 1ns/1ps
interface ucr_side_if;
	logic [3:0] modem_lvl;
	logic [3:0] modem_delta;
	logic msr_read;
	logic rx_push;
	logic [7:0] rx_byte;
	logic rhr_pop;
	logic lsr_read;
	logic [7:0] rhr_byte;
	logic rhr_ready;
	logic overrun;
	modport top (output modem_lvl, msr_read, rx_push, rx_byte, rhr_pop, lsr_read,
		input modem_delta, rhr_byte, rhr_ready, overrun);
	modport delta (input modem_lvl, msr_read, output modem_delta);
	modport hold (input rx_push, rx_byte, rhr_pop, lsr_read, output rhr_byte, rhr_ready, overrun);
endinterface

// ### verification/test_uart_channel_register_map.sv
// Self-checking bench for the channel register map
`timescale 1ns/1ps
module test_uart_channel_register_map;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic enh_enable = 1'b0;
	logic rx_push = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic [11:0] st = 12'h000;
	logic [3:0] lv = 4'h0;
	logic [3:0] old;
	logic [7:0] v, w;
	logic [31:0] seed = 32'h00000058;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire [3:0] reg_addr, isr_source;
	wire [7:0] reg_wdata;
	wire reg_wr, reg_rd, ln_parity_err, ln_framing_err, ln_break, ln_thr_empty, ln_tsr_empty, ln_fifo_err;
	wire isr_special, isr_flow_delta, cts_lvl, dsr_lvl, ri_lvl, cd_lvl;
	logic [7:0] reg_rdata, tx_byte, int_enable;
	logic [15:0] divisor;
	logic [3:0] baud_fraction, turnaround_delay, flow_hysteresis;
	logic [1:0] tx_trigger, rx_trigger, word_length, trigger_table;
	logic rd_valid, fast_ir, flow_char_parity, multidrop, rs485_invert, fifo_enable, rx_fifo_reset, tx_fifo_reset;
	logic dma_mode, stop_bits, parity_enable, even_parity, force_parity, send_break, divisor_access, dtr_ctl, rts_ctl;
	logic flow_select, tx_immediate, loopback, resume_on_any_char, ir_enable, baud_prescale, rx_mode_disable;
	logic tx_mode_disable, rx_disable, tx_disable, ir_rx_invert, auto_rs485, tx_load;
	// Status and modem levels come from two bench vectors
	assign {isr_flow_delta, isr_special, isr_source, ln_fifo_err, ln_tsr_empty, ln_thr_empty, ln_break,
		ln_framing_err, ln_parity_err} = st;
	assign {cd_lvl, ri_lvl, dsr_lvl, cts_lvl} = lv;
	ucr_chan_regs dut (.*);
	ucr_host_model host (.*);
	// Clock
	always #12.5 clk = ~clk;
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Expected status bytes from the applied levels
	function automatic logic [7:0] exp_lsr(logic [1:0] rx_flags);
		return {st[5:0], rx_flags};
	endfunction
	function automatic logic [7:0] exp_isr(logic fe);
		return {fe, fe, enh_enable ? st[11:10] : 2'b00, st[9:6]};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		host.rd(a, d, ok);
		chk("read valid", 16'h0001, {15'h0000, ok});
		chk(n, {8'h00, e}, {8'h00, d});
	endtask
	// Receiver push; byte line flips once the strobe drops
	task automatic push(input logic [7:0] b);
		@(posedge clk);
		#1;
		rx_byte = b;
		rx_push = 1'b1;
		@(posedge clk);
		#1;
		rx_push = 1'b0;
		rx_byte = ~b;
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		for (int a = 0; a < 16; a++) begin
			rdc("reset read", 4'(a), 8'h00);
		end
		host.wr(4'h9, 8'hff);
		rdc("unmapped", 4'h9, 8'h00);
		repeat (8) begin
			v = rnd();
			host.wr(4'h7, v);
			rdc("scratch", 4'h7, v);
		end
		v = rnd() & 8'h7f;
		host.wr(4'h3, v);
		rdc("line control", 4'h3, v);
		chk("line fields", {8'h00, v}, {8'h00, divisor_access, send_break, force_parity, even_parity, parity_enable,
			stop_bits, word_length});
		w = rnd();
		host.wr(4'h0, w);
		chk("transmit byte", {8'h00, w}, {8'h00, tx_byte});
		// Divisor access moves offsets zero to two onto the divisor
		host.wr(4'h3, 8'h80);
		v = rnd();
		w = rnd();
		host.wr(4'h0, v);
		host.wr(4'h1, w);
		host.wr(4'h2, v ^ w);
		rdc("divisor low", 4'h0, v);
		rdc("divisor high", 4'h1, w);
		rdc("fraction", 4'h2, v ^ w);
		chk("divisor", {w, v}, divisor);
		chk("fraction fields", {8'h00, v ^ w}, {8'h00, rs485_invert, multidrop, flow_char_parity, fast_ir,
			baud_fraction});
		host.wr(4'h3, 8'h00);
		// Enhanced bits refused first, then taken
		for (int e = 0; e < 2; e++) begin
			enh_enable = 1'(e);
			host.wr(4'h1, 8'hff);
			rdc("interrupt enable", 4'h1, e ? 8'hef : 8'h0f);
			host.wr(4'h4, 8'hff);
			rdc("modem control", 4'h4, e ? 8'hff : 8'h1f);
			chk("modem fields", e ? 16'h00ff : 16'h001f, {8'h00, baud_prescale, ir_enable, resume_on_any_char, loopback,
				tx_immediate, flow_select, rts_ctl, dtr_ctl});
			host.wr(4'h6, 8'ha5);
			chk("direction delay", e ? 16'h00a5 : 16'h0000, {8'h00, turnaround_delay, tx_disable, rx_disable,
				tx_mode_disable, rx_mode_disable});
			host.wr(4'h2, 8'hff);
			chk("fifo fields", e ? 16'h003f : 16'h0033, {10'h000, rx_trigger, tx_trigger, dma_mode, fifo_enable});
		end
		enh_enable = 1'b0;
		#1;
		chk("gated enables", 16'h000f, {8'h00, int_enable});
		enh_enable = 1'b1;
		#1;
		chk("restored enables", 16'h00ef, {8'h00, int_enable});
		// Status bytes follow random levels, enhanced flags toggling
		repeat (4) begin
			v = rnd();
			w = rnd();
			st = {w[3:0], v};
			rdc("line status", 4'h5, exp_lsr(2'b00));
			rdc("interrupt status", 4'h2, exp_isr(1'b1));
			enh_enable = ~enh_enable;
		end
		repeat (3) begin
			old = lv;
			v = rnd();
			lv = v[3:0];
			rdc("modem status", 4'h6, {lv, lv ^ old});
			rdc("modem cleared", 4'h6, {lv, 4'h0});
		end
		// Ready, then overrun on a second unread push
		st = 12'h000;
		v = rnd();
		w = rnd();
		push(v);
		rdc("ready set", 4'h5, exp_lsr(2'b01));
		rdc("receive byte", 4'h0, v);
		rdc("ready cleared", 4'h5, exp_lsr(2'b00));
		push(v);
		push(w);
		rdc("overrun set", 4'h5, exp_lsr(2'b11));
		rdc("newest byte", 4'h0, w);
		rdc("flags cleared", 4'h5, exp_lsr(2'b00));
		v = rnd();
		host.wr(4'h8, v);
		rdc("feature control", 4'h8, v);
		chk("feature fields", {8'h00, v}, {8'h00, trigger_table, auto_rs485, ir_rx_invert, flow_hysteresis});
		tally_and_finish();
	end
endmodule // test_uart_channel_register_map

// ### verification/ucr_chan_regs_properties.sv
// Concurrent checks on the channel register port and its decoded outputs
`timescale 1ns/1ps
module ucr_chan_regs_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rd_valid,
	input wire logic enh_enable,
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	input wire logic [7:0] int_enable,
	input wire logic rx_fifo_reset,
	input wire logic tx_fifo_reset,
	input wire logic divisor_access
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Port timing and decode
	a_read_answered: assert property (reg_rd |=> rd_valid) else $error("read not answered");
	a_valid_has_cause: assert property (rd_valid |-> $past(reg_rd)) else $error("stray read valid");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 8'h00) else $error("unmapped nonzero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read byte moved");
	a_tx_on_write: assert property (reg_wr && reg_addr == 4'h0 && !divisor_access |=> tx_load && tx_byte == $past(reg_wdata))
		else $error("transmit load missing");
	a_tx_has_cause: assert property (tx_load |-> $past(reg_wr && reg_addr == 4'h0 && !divisor_access))
		else $error("stray transmit load");
	// Stored fields, enhanced gating and fifo reset pulses
	a_scratch_echo: assert property ((reg_wr && reg_addr == 4'h7) ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == 4'h7)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("scratch changed");
	a_enh_gate: assert property (!enh_enable |-> int_enable[7:5] == 3'h0) else $error("enhanced enable leaks");
	a_ier_bit4_zero: assert property (int_enable[4] == 1'b0) else $error("enable bit 4 set");
	a_fifo_reset_pulse: assert property (reg_wr && reg_addr == 4'h2 && !divisor_access && reg_wdata[1] |=> rx_fifo_reset)
		else $error("receive reset missing");
	a_txfifo_reset_pulse: assert property (reg_wr && reg_addr == 4'h2 && !divisor_access && reg_wdata[2] |=> tx_fifo_reset)
		else $error("transmit reset missing");
endmodule // ucr_chan_regs_checker
bind ucr_chan_regs ucr_chan_regs_checker chk_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.rd_valid, .enh_enable, .tx_load, .tx_byte, .int_enable, .rx_fifo_reset, .tx_fifo_reset, .divisor_access);

// ### verification/ucr_host_model.sv
// Host side model driving the byte-wide register port
`timescale 1ns/1ps
module ucr_host_model (
	input wire logic clk,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rd_valid
);
	// Idle port at time zero
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write over one taking edge; released lines flip so stale values never pass
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// One read; answer registered at the taking edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
		v = rd_valid;
	endtask
endmodule // ucr_host_model
